//--- logic/wakeup_cmp_pkg.sv
// Package with register map, field layout and reset values for the wake-up compare block
package wakeup_cmp_pkg;
  // Register offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_AMP_CFG = 8'h32;
  localparam logic [7:0] IDX_AMP_REF = 8'h33;
  localparam logic [7:0] IDX_AMP_AVG = 8'h34;
  localparam logic [7:0] IDX_AMP_RES = 8'h35;
  localparam logic [7:0] IDX_PH_CFG = 8'h36;
  localparam logic [7:0] IDX_PH_REF = 8'h37;
  localparam logic [7:0] IDX_PH_AVG = 8'h38;
  localparam logic [7:0] IDX_PH_RES = 8'h39;
  localparam logic [7:0] IDX_WAKE_CTL = 8'h40;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h41;
  localparam logic [7:0] IDX_IRQ_EN = 8'h42;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h43;
  localparam logic [7:0] IDX_CMD = 8'h44;
  // Configuration field positions
  localparam int THR_HI = 7;
  localparam int THR_LO = 4;
  localparam int KEEP_BIT = 3;
  localparam int WGT_HI = 2;
  localparam int WGT_LO = 1;
  localparam int USE_AVG_BIT = 0;
  // Wake control bits and interrupt status bits
  localparam int WAKE_AMP_BIT = 0;
  localparam int WAKE_PH_BIT = 1;
  localparam int IRQ_AMP_BIT = 0;
  localparam int IRQ_PH_BIT = 1;
  localparam int CMD_DEFAULT_BIT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
endpackage

//--- logic/amp_phase_wakeup_compare.sv
// Wake-up amplitude and phase compare with running averages and an APB slave
//
// Behaviour
// - Bits 7..4 of each config hold threshold; interrupt when difference exceeds it.
// - Config bit 3 set keeps interrupting measurements in the average; clear excludes them.
// - Config bits 2..1 choose average weight 4, 8, 16 or 32.
// - Amplitude config bit 0 selects running average, else written reference, as reference.
// - Phase config bit 0 selects running average, else written reference, as reference.
// - Configs and amplitude reference clear at reset and on set-default command.
// - Amplitude average and result registers clear at reset and on set-default.
// - Amplitude average readable at 0x34; writes there are ignored.
// - Latest amplitude result readable at 0x35.
// - With amplitude wake enable, each timer timeout measures amplitude and compares it.
// - With phase wake enable, each timer timeout measures phase and compares it.
`timescale 1ns/1ps
module amp_phase_wakeup_compare
  import wakeup_cmp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wakeup_timeout,
  output logic amp_meas_req,
  output logic phase_meas_req,
  input wire logic amp_meas_done,
  input wire logic [DATA_W-1:0] amp_meas_value,
  input wire logic phase_meas_done,
  input wire logic [DATA_W-1:0] phase_meas_value,
  output logic irq
);
  // Only eight-bit results are served by the compare and average datapath
  if (DATA_W != 8) begin : g_width_check
    $error("DATA_W must be 8");
  end

  logic [7:0] amp_cfg_r, amp_ref_r, amp_avg_r, amp_res_r;
  logic [7:0] ph_cfg_r, ph_ref_r, ph_avg_r, ph_res_r;
  logic [1:0] wake_ctl_r, irq_stat_r, irq_en_r;
  logic [7:0] amp_avg_nxt, ph_avg_nxt;
  logic amp_req_r, ph_req_r, irq_r, pready_r;
  logic [31:0] prdata_r;

  // Difference magnitude between a result and a reference
  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a >= b) ? 8'(a - b) : 8'(b - a);
  endfunction

  // Running average step with weight 4/8/16/32 chosen by a 2-bit code
  function automatic logic [7:0] avg_step(input logic [7:0] old, input logic [7:0] nv,
                                          input logic [1:0] wcode);
    logic signed [9:0] d;
    logic signed [9:0] s;
    d = 10'(signed'({2'b00, nv})) - 10'(signed'({2'b00, old}));
    s = d >>> (2 + wcode);
    avg_step = 8'(10'(signed'({2'b00, old})) + s);
  endfunction

  // APB decode; index is the word address
  wire [9:0] idx = paddr[11:2];
  wire acc = psel && penable && !pready_r;
  wire wr = acc && pwrite;
  wire known = idx inside {10'(IDX_AMP_CFG), 10'(IDX_AMP_REF), 10'(IDX_AMP_AVG),
    10'(IDX_AMP_RES), 10'(IDX_PH_CFG), 10'(IDX_PH_REF), 10'(IDX_PH_AVG), 10'(IDX_PH_RES),
    10'(IDX_WAKE_CTL), 10'(IDX_IRQ_STAT), 10'(IDX_IRQ_EN), 10'(IDX_IRQ_CLR), 10'(IDX_CMD)};
  wire set_default = wr && idx == 10'(IDX_CMD) && pwdata[CMD_DEFAULT_BIT];
  wire clr_wr = wr && idx == 10'(IDX_IRQ_CLR);

  // Reference selection and threshold compare
  wire [7:0] amp_ref_sel = amp_cfg_r[USE_AVG_BIT] ? amp_avg_r : amp_ref_r;
  wire [7:0] ph_ref_sel = ph_cfg_r[USE_AVG_BIT] ? ph_avg_r : ph_ref_r;
  wire amp_hit = amp_meas_done &&
    abs_diff(amp_meas_value, amp_ref_sel) > {4'h0, amp_cfg_r[THR_HI:THR_LO]};
  wire ph_hit = phase_meas_done &&
    abs_diff(phase_meas_value, ph_ref_sel) > {4'h0, ph_cfg_r[THR_HI:THR_LO]};
  wire amp_accept = amp_meas_done && (!amp_hit || amp_cfg_r[KEEP_BIT]);
  wire ph_accept = phase_meas_done && (!ph_hit || ph_cfg_r[KEEP_BIT]);
  assign amp_avg_nxt = avg_step(amp_avg_r, amp_meas_value, amp_cfg_r[WGT_HI:WGT_LO]);
  assign ph_avg_nxt = avg_step(ph_avg_r, phase_meas_value, ph_cfg_r[WGT_HI:WGT_LO]);
  wire [1:0] events = {ph_hit, amp_hit};
  wire [1:0] stat_nxt = events | (irq_stat_r & ~(clr_wr ? pwdata[1:0] : 2'h0));

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    unique case (idx)
      10'(IDX_AMP_CFG): rd_byte = amp_cfg_r;
      10'(IDX_AMP_REF): rd_byte = amp_ref_r;
      10'(IDX_AMP_AVG): rd_byte = amp_avg_r;
      10'(IDX_AMP_RES): rd_byte = amp_res_r;
      10'(IDX_PH_CFG): rd_byte = ph_cfg_r;
      10'(IDX_PH_REF): rd_byte = ph_ref_r;
      10'(IDX_PH_AVG): rd_byte = ph_avg_r;
      10'(IDX_PH_RES): rd_byte = ph_res_r;
      10'(IDX_WAKE_CTL): rd_byte = {6'h00, wake_ctl_r};
      10'(IDX_IRQ_STAT): rd_byte = {6'h00, irq_stat_r};
      10'(IDX_IRQ_EN): rd_byte = {6'h00, irq_en_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus answer: pready one cycle after penable rises, one wait state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready_r <= acc;
      prdata_r <= (acc && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      pslverr <= acc && !known;
    end
  end
  assign pready = pready_r;
  assign prdata = prdata_r;

  // Software-written configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      amp_cfg_r <= RST_BYTE;
      amp_ref_r <= RST_BYTE;
      ph_cfg_r <= RST_BYTE;
      ph_ref_r <= RST_BYTE;
      wake_ctl_r <= RST_IRQ;
      irq_en_r <= RST_IRQ;
    end else if (set_default) begin
      amp_cfg_r <= RST_BYTE;
      amp_ref_r <= RST_BYTE;
      ph_cfg_r <= RST_BYTE;
      ph_ref_r <= RST_BYTE;
      wake_ctl_r <= RST_IRQ;
      irq_en_r <= RST_IRQ;
    end else if (wr) begin
      if (idx == 10'(IDX_AMP_CFG)) amp_cfg_r <= pwdata[7:0];
      if (idx == 10'(IDX_AMP_REF)) amp_ref_r <= pwdata[7:0];
      if (idx == 10'(IDX_PH_CFG)) ph_cfg_r <= pwdata[7:0];
      if (idx == 10'(IDX_PH_REF)) ph_ref_r <= pwdata[7:0];
      if (idx == 10'(IDX_WAKE_CTL)) wake_ctl_r <= pwdata[1:0];
      if (idx == 10'(IDX_IRQ_EN)) irq_en_r <= pwdata[1:0];
    end
  end

  // Measurement results and running averages
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      amp_avg_r <= RST_BYTE;
      amp_res_r <= RST_BYTE;
      ph_avg_r <= RST_BYTE;
      ph_res_r <= RST_BYTE;
    end else if (set_default) begin
      amp_avg_r <= RST_BYTE;
      amp_res_r <= RST_BYTE;
      ph_avg_r <= RST_BYTE;
      ph_res_r <= RST_BYTE;
    end else begin
      if (amp_meas_done) amp_res_r <= amp_meas_value;
      if (amp_accept) amp_avg_r <= amp_avg_nxt;
      if (phase_meas_done) ph_res_r <= phase_meas_value;
      if (ph_accept) ph_avg_r <= ph_avg_nxt;
    end
  end

  // Timeout launches enabled measurements; sticky status, set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      amp_req_r <= 1'b0;
      ph_req_r <= 1'b0;
      irq_stat_r <= RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      amp_req_r <= wakeup_timeout && wake_ctl_r[WAKE_AMP_BIT];
      ph_req_r <= wakeup_timeout && wake_ctl_r[WAKE_PH_BIT];
      irq_stat_r <= set_default ? RST_IRQ : stat_nxt;
      irq_r <= !set_default && |(stat_nxt & irq_en_r);
    end
  end
  assign amp_meas_req = amp_req_r;
  assign phase_meas_req = ph_req_r;
  assign irq = irq_r;

  // Assertions

  // Independent models of the threshold compare and of the average step
  wire [8:0] amp_ref_chk = {1'b0, (amp_cfg_r[USE_AVG_BIT] ? amp_avg_r : amp_ref_r)};
  wire [8:0] ph_ref_chk = {1'b0, (ph_cfg_r[USE_AVG_BIT] ? ph_avg_r : ph_ref_r)};
  wire [8:0] amp_thr_chk = {5'h00, amp_cfg_r[THR_HI:THR_LO]};
  wire [8:0] ph_thr_chk = {5'h00, ph_cfg_r[THR_HI:THR_LO]};
  wire amp_far_chk = ({1'b0, amp_meas_value} > amp_ref_chk + amp_thr_chk) ||
    (amp_ref_chk > {1'b0, amp_meas_value} + amp_thr_chk);
  wire ph_far_chk = ({1'b0, phase_meas_value} > ph_ref_chk + ph_thr_chk) ||
    (ph_ref_chk > {1'b0, phase_meas_value} + ph_thr_chk);
  // Mean (old * (w - 1) + new) / w equals old plus the floored step
  wire [13:0] amp_w_chk = {8'h00, 6'h04 << amp_cfg_r[WGT_HI:WGT_LO]};
  wire [13:0] ph_w_chk = {8'h00, 6'h04 << ph_cfg_r[WGT_HI:WGT_LO]};
  wire [13:0] amp_sum_chk = {6'h00, amp_avg_r} * (amp_w_chk - 14'h0001) +
    {6'h00, amp_meas_value};
  wire [13:0] ph_sum_chk = {6'h00, ph_avg_r} * (ph_w_chk - 14'h0001) +
    {6'h00, phase_meas_value};
  wire [7:0] amp_quo_chk = 8'(amp_sum_chk / amp_w_chk);
  wire [7:0] ph_quo_chk = 8'(ph_sum_chk / ph_w_chk);

  // Threshold compare, sticky status and interrupt level
  amp_hit_exact_a: assert property (@(posedge clk) disable iff (sys_rst)
    amp_meas_done |-> amp_hit == amp_far_chk)
    else $error("amplitude compare wrong");
  ph_hit_exact_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase_meas_done |-> ph_hit == ph_far_chk)
    else $error("phase compare wrong");
  irq_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    clr_wr && pwdata[IRQ_AMP_BIT] && !amp_hit |=> !irq_stat_r[IRQ_AMP_BIT])
    else $error("status clear ignored");
  stat_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    irq_stat_r[IRQ_AMP_BIT] && !(clr_wr && pwdata[IRQ_AMP_BIT]) && !set_default
    |=> irq_stat_r[IRQ_AMP_BIT])
    else $error("status bit lost");
  irq_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    |(irq_stat_r & irq_en_r) && !clr_wr && !set_default |=> irq)
    else $error("enabled status without irq");
  irq_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    irq_stat_r == 2'h0 && !amp_hit && !ph_hit |=> !irq)
    else $error("irq without status");

  // Running average
  ph_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_hit && !ph_cfg_r[KEEP_BIT] && !set_default) |=> $stable(ph_avg_r))
    else $error("excluded phase sample changed average");
  ph_weight_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_accept && !set_default && ph_cfg_r[WGT_HI:WGT_LO] == 2'h3 &&
     phase_meas_value == 8'h80 && ph_avg_r == 8'h00) |=> ph_avg_r == 8'h04)
    else $error("weight 32 step wrong");
  amp_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    amp_accept && !set_default |=> amp_avg_r == $past(amp_quo_chk))
    else $error("amplitude average step wrong");
  ph_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    ph_accept && !set_default |=> ph_avg_r == $past(ph_quo_chk))
    else $error("phase average step wrong");

  // Set-default command
  dflt_ph_a: assert property (@(posedge clk) disable iff (sys_rst)
    set_default |=> ph_ref_r == 8'h00 && ph_avg_r == 8'h00 && ph_res_r == 8'h00)
    else $error("set default missed phase state");
  dflt_ctl_a: assert property (@(posedge clk) disable iff (sys_rst)
    set_default |=> wake_ctl_r == 2'h0 && irq_en_r == 2'h0 && irq_stat_r == 2'h0
    && !irq)
    else $error("set default missed control");

  // Result capture and measurement launch
  amp_res_a: assert property (@(posedge clk) disable iff (sys_rst)
    amp_meas_done && !set_default |=> amp_res_r == $past(amp_meas_value))
    else $error("amplitude result not captured");
  ph_res_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase_meas_done && !set_default |=> ph_res_r == $past(phase_meas_value))
    else $error("phase result not captured");
  amp_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wakeup_timeout |=> !amp_meas_req)
    else $error("amplitude launched without timeout");
  amp_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wake_ctl_r[WAKE_AMP_BIT] |=> !amp_meas_req)
    else $error("amplitude launched while disabled");
  ph_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    wakeup_timeout && wake_ctl_r[WAKE_PH_BIT] |=> phase_meas_req)
    else $error("phase not launched");
  ph_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wake_ctl_r[WAKE_PH_BIT] |=> !phase_meas_req)
    else $error("phase launched while disabled");

  // Register bus
  ready_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_a: assert property (@(posedge clk) disable iff (sys_rst)
    acc && !known |=> pready && pslverr)
    else $error("unmapped access not refused");
  err_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("error without ready");
  rd_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(acc && !pwrite) |=> prdata == 32'h0000_0000)
    else $error("read data outside read answer");
  cfg_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && idx == 10'(IDX_AMP_CFG) |=> amp_cfg_r == $past(pwdata[7:0]))
    else $error("amplitude config write lost");
  ph_cfg_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && idx == 10'(IDX_PH_CFG) |=> ph_cfg_r == $past(pwdata[7:0]))
    else $error("phase config write lost");
  ref_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && idx == 10'(IDX_AMP_REF) |=> amp_ref_r == $past(pwdata[7:0]))
    else $error("amplitude reference write lost");
  stat_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && idx == 10'(IDX_IRQ_STAT) && !amp_hit && !ph_hit |=> $stable(irq_stat_r))
    else $error("status write took effect");

  // Checks kept from the first cut of the block
  amp_irq_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (amp_hit && !set_default) |=> irq_stat_r[IRQ_AMP_BIT])
    else $error("amplitude hit did not set status");
  ph_irq_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_hit && !set_default) |=> irq_stat_r[IRQ_PH_BIT])
    else $error("phase hit did not set status");
  amp_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
    (amp_hit && !amp_cfg_r[KEEP_BIT] && !set_default) |=> $stable(amp_avg_r))
    else $error("excluded sample changed average");
  amp_weight_a: assert property (@(posedge clk) disable iff (sys_rst)
    (amp_accept && !set_default && amp_cfg_r[2:1] == 2'h0 && amp_meas_value == 8'h80
     && amp_avg_r == 8'h00) |=> amp_avg_r == 8'h20)
    else $error("weight 4 step wrong");
  amp_ref_a: assert property (@(posedge clk) disable iff (sys_rst)
    amp_meas_done && !amp_cfg_r[0] && amp_meas_value == amp_ref_r |-> !amp_hit)
    else $error("written reference not used");
  ph_ref_a: assert property (@(posedge clk) disable iff (sys_rst)
    phase_meas_done && ph_cfg_r[USE_AVG_BIT] && phase_meas_value >= ph_avg_r &&
    8'(phase_meas_value - ph_avg_r) <= {4'h0, ph_cfg_r[THR_HI:THR_LO]} |-> !ph_hit)
    else $error("phase average not used");
  dflt_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    set_default |=> amp_cfg_r == 8'h00 && amp_ref_r == 8'h00 && ph_cfg_r == 8'h00)
    else $error("set default missed config");
  dflt_disp_a: assert property (@(posedge clk) disable iff (sys_rst)
    set_default |=> amp_avg_r == 8'h00 && amp_res_r == 8'h00)
    else $error("set default missed display");
  avg_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && idx == 10'(IDX_AMP_AVG) && !amp_meas_done |=> $stable(amp_avg_r))
    else $error("write changed average");
  res_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    acc && !pwrite && idx == 10'(IDX_AMP_RES) |=> prdata[7:0] == $past(amp_res_r))
    else $error("result read wrong");
  amp_launch_a: assert property (@(posedge clk) disable iff (sys_rst)
    wakeup_timeout && wake_ctl_r[0] |=> amp_meas_req)
    else $error("amplitude not launched");
  ph_launch_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wakeup_timeout |=> !phase_meas_req)
    else $error("phase launched without timeout");
  irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    irq == |$past(stat_nxt & irq_en_r & {2{!set_default}}))
    else $error("irq level wrong");
  hit_c: cover property (@(posedge clk) disable iff (sys_rst) amp_hit ##1 irq);
  avg_c: cover property (@(posedge clk) disable iff (sys_rst) amp_accept && amp_cfg_r[0]);
  ph_c: cover property (@(posedge clk) disable iff (sys_rst) ph_hit && ph_cfg_r[KEEP_BIT]);
  excl_c: cover property (@(posedge clk) disable iff (sys_rst) amp_hit && !amp_cfg_r[KEEP_BIT]);
  dflt_c: cover property (@(posedge clk) disable iff (sys_rst) set_default);
endmodule

//--- tb/test_amp_phase_wakeup_compare.sv
// Self-checking testbench for the wake-up amplitude and phase compare block
`timescale 1ns/1ps
module test_amp_phase_wakeup_compare
  import wakeup_cmp_pkg::*;
;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, wakeup_timeout;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic amp_meas_req, phase_meas_req, amp_meas_done, phase_meas_done;
  logic [7:0] amp_meas_value, phase_meas_value;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;

  amp_phase_wakeup_compare u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wakeup_timeout(wakeup_timeout),
    .amp_meas_req(amp_meas_req), .phase_meas_req(phase_meas_req),
    .amp_meas_done(amp_meas_done), .amp_meas_value(amp_meas_value),
    .phase_meas_done(phase_meas_done), .phase_meas_value(phase_meas_value), .irq(irq));

  // Clock of 4 ns and a ceiling on the run length
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results;
    end
  end

  task automatic results;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ix, {24'h0, d}, r, e);
  endtask

  task automatic rdc(input logic [7:0] ix, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, ix, 32'h0, r, e);
    chk(r, {24'h0, exp});
    chk({31'h0, e}, 32'h0);
  endtask

  // Set-default command, then wake enables and interrupt enables again
  task automatic dflt(input logic [7:0] wake);
    wr(IDX_CMD, 8'h01);
    wr(IDX_WAKE_CTL, wake);
    wr(IDX_IRQ_EN, 8'h03);
  endtask

  // Timer timeout, expect a request, then hand back one result
  task automatic meas(input logic ph, input logic [7:0] v);
    int k;
    logic seen;
    seen = 1'b0;
    wakeup_timeout <= 1'b1;
    @(posedge clk);
    wakeup_timeout <= 1'b0;
    for (k = 0; k < 4 && !seen; k++) begin
      @(posedge clk);
      seen = ph ? (phase_meas_req === 1'b1) : (amp_meas_req === 1'b1);
    end
    chk({31'h0, seen}, 32'h1);
    amp_meas_value <= v;
    phase_meas_value <= v;
    amp_meas_done <= !ph;
    phase_meas_done <= ph;
    @(posedge clk);
    amp_meas_done <= 1'b0;
    phase_meas_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic zeros;
    rdc(IDX_AMP_CFG, 8'h00);
    rdc(IDX_AMP_REF, 8'h00);
    rdc(IDX_PH_CFG, 8'h00);
    rdc(IDX_AMP_AVG, 8'h00);
    rdc(IDX_AMP_RES, 8'h00);
  endtask

  task automatic t_access;
    logic [31:0] r;
    logic e;
    wr(IDX_AMP_AVG, 8'hFF);
    rdc(IDX_AMP_AVG, 8'h00);
    wr(IDX_AMP_CFG, 8'hA5);
    rdc(IDX_AMP_CFG, 8'hA5);
    apb(1'b0, 8'h3F, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("access test done");
  endtask

  // Written reference, threshold boundary, mask and clear
  task automatic t_amp_ref;
    dflt(8'h01);
    wr(IDX_AMP_CFG, 8'h40);
    wr(IDX_AMP_REF, 8'h40);
    meas(1'b0, 8'h44);
    rdc(IDX_IRQ_STAT, 8'h00);
    rdc(IDX_AMP_RES, 8'h44);
    meas(1'b0, 8'h40);
    rdc(IDX_IRQ_STAT, 8'h00);
    meas(1'b0, 8'h3B);
    rdc(IDX_IRQ_STAT, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_EN, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_EN, 8'h03);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_CLR, 8'h03);
    rdc(IDX_IRQ_STAT, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("reference test done");
  endtask

  // Every weight code with the interrupting sample kept
  task automatic t_weight;
    int c;
    for (c = 0; c < 4; c++) begin
      dflt(8'h03);
      wr(IDX_AMP_CFG, {4'hF, 1'b1, c[1:0], 1'b1});
      wr(IDX_PH_CFG, {4'hF, 1'b1, c[1:0], 1'b1});
      meas(1'b0, 8'h80);
      meas(1'b1, 8'h80);
      rdc(IDX_AMP_AVG, 8'(8'h80 >> (2 + c)));
      rdc(IDX_PH_AVG, 8'(8'h80 >> (2 + c)));
      rdc(IDX_IRQ_STAT, 8'h03);
    end
    $display("weight test done");
  endtask

  // Interrupting sample excluded; average, not reference, is compared
  task automatic t_exclude;
    dflt(8'h01);
    wr(IDX_AMP_REF, 8'h80);
    wr(IDX_AMP_CFG, 8'hF1);
    meas(1'b0, 8'h80);
    rdc(IDX_IRQ_STAT, 8'h01);
    rdc(IDX_AMP_AVG, 8'h00);
    meas(1'b0, 8'h08);
    rdc(IDX_AMP_AVG, 8'h02);
    $display("exclude test done");
  endtask

  task automatic t_phase;
    dflt(8'h02);
    wr(IDX_PH_REF, 8'h50);
    wr(IDX_PH_CFG, 8'hF1);
    meas(1'b1, 8'h08);
    rdc(IDX_IRQ_STAT, 8'h00);
    rdc(IDX_PH_AVG, 8'h02);
    wr(IDX_PH_CFG, 8'h10);
    meas(1'b1, 8'h51);
    rdc(IDX_IRQ_STAT, 8'h00);
    meas(1'b1, 8'h4E);
    rdc(IDX_IRQ_STAT, 8'h02);
    chk({31'h0, irq}, 32'h1);
    $display("phase test done");
  endtask

  task automatic t_default;
    dflt(8'h01);
    wr(IDX_AMP_CFG, 8'hFF);
    wr(IDX_AMP_REF, 8'h77);
    wr(IDX_PH_CFG, 8'hFF);
    meas(1'b0, 8'h33);
    wr(IDX_CMD, 8'h01);
    zeros;
    rdc(IDX_IRQ_STAT, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("default test done");
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wakeup_timeout = 1'b0;
    amp_meas_done = 1'b0;
    phase_meas_done = 1'b0;
    amp_meas_value = 8'h00;
    phase_meas_value = 8'h00;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    zeros;
    $display("reset test done");
    t_access;
    t_amp_ref;
    t_weight;
    t_exclude;
    t_phase;
    t_default;
    results;
  end
endmodule
